// File: hdl/snav_pkg.sv
// constants for the notch adaptive tracking and speed-loop gain block
// assumes one 250 MHz clock and an ahb-lite register port with word registers
package snav_pkg;
  // register byte addresses
  localparam logic [7:0] SNAV_OFS_NOTCH1   = 8'h00;
  localparam logic [7:0] SNAV_OFS_NOTCH2   = 8'h04;
  localparam logic [7:0] SNAV_OFS_NOTCH4   = 8'h08;
  localparam logic [7:0] SNAV_OFS_NOTCH5   = 8'h0c;
  localparam logic [7:0] SNAV_OFS_FW_TEN   = 8'h10;
  localparam logic [7:0] SNAV_OFS_FW_ONE   = 8'h14;
  localparam logic [7:0] SNAV_OFS_GAIN1    = 8'h18;
  localparam logic [7:0] SNAV_OFS_GAIN2    = 8'h1c;
  localparam logic [7:0] SNAV_OFS_VCS      = 8'h20;
  localparam logic [7:0] SNAV_OFS_VMAX     = 8'h24;
  localparam logic [7:0] SNAV_OFS_EST      = 8'h28;
  localparam logic [7:0] SNAV_OFS_MON      = 8'h2c;
  localparam logic [7:0] SNAV_OFS_GAIN_EFF = 8'h30;
  localparam logic [7:0] SNAV_OFS_EFF12    = 8'h34;
  localparam logic [7:0] SNAV_OFS_EFF45    = 8'h38;

  // function word ten fields
  localparam int SNAV_FW10_ALLF   = 15;
  localparam int SNAV_FW10_SEL_LO = 12;
  localparam int SNAV_FW10_ADE_LO = 8;
  localparam int SNAV_FW10_HLD_LO = 6;
  localparam int SNAV_FW10_RNG_LO = 4;
  localparam int SNAV_FW10_SNS_LO = 0;
  // function word one field
  localparam int SNAV_FW1_JIT_LO  = 4;

  // setting limits
  localparam logic [15:0]        SNAV_NOTCH_MAX = 16'h08ca;  // 2250 hz
  localparam logic [15:0]        SNAV_EST_MIN   = 16'h0096;  // 150 hz
  localparam logic [15:0]        SNAV_EST_MAX   = 16'h0384;  // 900 hz
  localparam logic [15:0]        SNAV_NOTCH3_HZ = 16'h1194;  // 4500 hz
  localparam logic signed [15:0] SNAV_G1_MIN    = 16'sh0001;
  localparam logic signed [15:0] SNAV_G_MAX     = 16'sh7530;  // 30000
  localparam logic signed [15:0] SNAV_G2_MIN    = -16'sh03e8; // -1000
  localparam logic [15:0]        SNAV_VCS_MAX   = 16'h270f;  // 9999 r/min
  localparam logic [23:0]        SNAV_LIM_NUM   = 24'h000073; // limit = max * 115 / 100
  localparam logic [23:0]        SNAV_LIM_DEN   = 24'h000064;
  localparam logic [3:0]         SNAV_SNS_ZERO  = 4'ha;      // code 0 acts as code a
  localparam logic [19:0]        SNAV_PCT_DEN   = 20'h0000a; // window step is 10 %

  // monitor select codes
  localparam logic [2:0] SNAV_SEL_EST = 3'h0;
  localparam logic [2:0] SNAV_SEL_N1  = 3'h1;
  localparam logic [2:0] SNAV_SEL_N2  = 3'h2;
  localparam logic [2:0] SNAV_SEL_N3  = 3'h3;
  localparam logic [2:0] SNAV_SEL_N4  = 3'h4;
  localparam logic [2:0] SNAV_SEL_N5  = 3'h5;

  // reset values
  localparam logic [15:0] SNAV_RST_NOTCH = 16'h0000;
  localparam logic [15:0] SNAV_RST_FW    = 16'h0000;
  localparam logic [15:0] SNAV_RST_GAIN1 = 16'h0064;
  localparam logic [15:0] SNAV_RST_ZERO  = 16'h0000;

  // timing: display hold step
  localparam int SNAV_CLK_HZ     = 250_000_000;
  localparam int SNAV_HOLD_STEP_S = 4;
  localparam int SNAV_HOLD_STEP_CYC = SNAV_HOLD_STEP_S * SNAV_CLK_HZ;

  // detection threshold step per sensitivity code
  localparam logic [15:0] SNAV_SENS_STEP = 16'h0040;
endpackage : snav_pkg

// File: hdl/snav_ctrl.sv
// notch adaptive tracking, monitor select, standstill jitter filter, variable speed gain
// assumes estimator, feedback and motion inputs are synchronous to hclk
//
// Notes on behaviour
// [R1] notch 4/5 take 0..2250 hz, zero disables
// [R2] software avoids notch settings at or below 80 hz
// [R3] estimate during rapid traverse, retune only at rest
// [R4] only filters 1,2,4,5 adapt; filter 3 fixed
// [R5] retune nearest enabled filter whose window holds estimate
// [R6] estimates only considered between 150 and 900 hz
// [R7] adaptation moves frequency only, never depth
// [R8] filter 5 all-frequency bit widens its window fully
// [R9] all-frequency filter 5 takes otherwise unclaimed resonance
// [R10] reprogramming keeps effective value if still inside window
// [R11] bits 8,9,a,b enable adaptation for 1,2,4,5
// [R12] monitor select shows estimate or filter frequencies
// [R13] estimate display hold 4, 8, 12 or 16 s
// [R14] window width plus/minus 10,20,30,40 percent
// [R15] sensitivity 0 equals a; 1 high to f low
// [R16] drop 0..3 feedback pulses after polarity reversal
// [R17] pulse dropping only while the motor is stopped
// [R18] primary speed gain limited to 1..30000
// [R19] secondary gain at 1.15 x max speed, -1000..30000
// [R20] change speed 0..9999 r/min, zero disables
// [R21] gain moves linearly between change and limit speed
`timescale 1ns/100ps
module snav_ctrl
  import snav_pkg::*;
#(
  parameter logic [31:0] HOLD_STEP_CYC = 32'(SNAV_HOLD_STEP_CYC)
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               clk_en,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               rapid_traverse,
  input  wire logic               axis_at_rest,
  input  wire logic               osc_valid,
  input  wire logic [15:0]        osc_freq,
  input  wire logic [15:0]        osc_amplitude,
  input  wire logic               motor_stopped,
  input  wire logic               fb_pulse,
  input  wire logic               fb_dir,
  input  wire logic [15:0]        motor_speed,
  output logic                    fb_pulse_out,
  output logic                    fb_dir_out,
  output logic [3:0][15:0]        notch_eff_freq,
  output logic                    notch3_enable,
  output logic [15:0]             resonance_monitor_value,
  output logic signed [16:0]      speed_gain_effective
);

  typedef struct packed {
    logic [3:0][15:0]   prog;     // filters 1,2,4,5
    logic [3:0][15:0]   eff;
    logic [15:0]        fw10;
    logic [15:0]        fw1;
    logic signed [15:0] g1;
    logic signed [15:0] g2;
    logic [15:0]        gain_change_speed;
    logic [15:0]        vmax;
    logic [15:0]        est;
    logic               pend;
    logic [31:0]        hold;
    logic               wr_pend;
    logic [7:0]         wr_addr;
    logic [31:0]        rdata;
    logic               last_dir;
    logic [1:0]         drop;
    logic               pulse_out;
    logic               dir_out;
    logic signed [16:0] gain_eff;
    logic [15:0]        mon;
  } snav_state_s;

  snav_state_s s_q;
  snav_state_s s_d;

  // half-width of the window around prog
  function automatic logic [15:0] win_half(input logic [15:0] prog, input logic [1:0] rng);
    logic [19:0] p;
    p = (20'(prog) * 20'({2'b00, rng} + 4'h1)) / SNAV_PCT_DEN; // [R14]
    return p[15:0];
  endfunction : win_half

  function automatic logic in_win(input logic [15:0] f, input logic [15:0] prog,
                                  input logic [1:0] rng);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = 17'(prog) - 17'(win_half(prog, rng));
    hi = 17'(prog) + 17'(win_half(prog, rng));
    return (17'(f) >= lo) && (17'(f) <= hi);
  endfunction : in_win

  function automatic logic [15:0] clamp_notch(input logic [15:0] v);
    return (v > SNAV_NOTCH_MAX) ? SNAV_NOTCH_MAX : v;           // [R1]
  endfunction : clamp_notch

  function automatic logic [15:0] diff16(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : diff16

  logic        addr_ok;
  logic [31:0] rd_word;

  always_comb begin
    addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
    rd_word = 32'h00000000;
    if (addr_ok) begin
      unique case (haddr[7:0])
        SNAV_OFS_NOTCH1:   rd_word = {16'h0000, s_q.prog[0]};
        SNAV_OFS_NOTCH2:   rd_word = {16'h0000, s_q.prog[1]};
        SNAV_OFS_NOTCH4:   rd_word = {16'h0000, s_q.prog[2]};
        SNAV_OFS_NOTCH5:   rd_word = {16'h0000, s_q.prog[3]};
        SNAV_OFS_FW_TEN:   rd_word = {16'h0000, s_q.fw10};
        SNAV_OFS_FW_ONE:   rd_word = {16'h0000, s_q.fw1};
        SNAV_OFS_GAIN1:    rd_word = {16'h0000, s_q.g1};
        SNAV_OFS_GAIN2:    rd_word = {16'h0000, s_q.g2};
        SNAV_OFS_VCS:      rd_word = {16'h0000, s_q.gain_change_speed};
        SNAV_OFS_VMAX:     rd_word = {16'h0000, s_q.vmax};
        SNAV_OFS_EST:      rd_word = {15'h0000, s_q.pend, s_q.est};
        SNAV_OFS_MON:      rd_word = {16'h0000, s_q.mon};
        SNAV_OFS_GAIN_EFF: rd_word = {{15{s_q.gain_eff[16]}}, s_q.gain_eff};
        SNAV_OFS_EFF12:    rd_word = {s_q.eff[1], s_q.eff[0]};
        SNAV_OFS_EFF45:    rd_word = {s_q.eff[3], s_q.eff[2]};
        default:           rd_word = 32'h00000000;
      endcase
    end
  end

  logic [1:0]         rng;
  logic [3:0]         ade;
  logic               allf;
  logic [3:0]         sns;
  logic [15:0]        thr;
  logic               take;
  logic [2:0]         best;
  logic [15:0]        best_d;
  logic [15:0]        wv;
  logic signed [15:0] gv;
  logic [23:0]        lim;
  logic signed [40:0] num;
  logic signed [40:0] den;
  logic signed [40:0] step;
  logic [1:0]         jit;

  always_comb begin
    s_d    = s_q;
    rng    = s_q.fw10[SNAV_FW10_RNG_LO +: 2];
    ade    = s_q.fw10[SNAV_FW10_ADE_LO +: 4];                      // [R11]
    allf   = s_q.fw10[SNAV_FW10_ALLF];
    sns    = s_q.fw10[SNAV_FW10_SNS_LO +: 4];
    thr    = 16'h0000;
    take   = 1'b0;
    best   = 3'h4;
    best_d = 16'hffff;
    wv     = hwdata[15:0];
    gv     = hwdata[15:0];
    lim    = 24'h000000;
    num    = 41'sh0;
    den    = 41'sh1;
    step   = 41'sh0;
    jit    = s_q.fw1[SNAV_FW1_JIT_LO +: 2];

    // bus: address phase registers read data, write lands in data phase
    s_d.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.rdata = hwrite ? 32'h00000000 : rd_word;
      s_d.wr_pend = hwrite && addr_ok;
      s_d.wr_addr = haddr[7:0];
    end
    if (s_q.wr_pend) begin
      unique case (s_q.wr_addr)
        SNAV_OFS_NOTCH1, SNAV_OFS_NOTCH2, SNAV_OFS_NOTCH4, SNAV_OFS_NOTCH5: begin
          for (int i = 0; i < 4; i++) begin
            if (s_q.wr_addr == 8'(i * 4)) begin
              s_d.prog[i] = clamp_notch(wv);                        // [R1]
              // keep the tuned value while it still sits in the new window
              if (clamp_notch(wv) != 16'h0000 && s_q.eff[i] != 16'h0000 &&
                  in_win(s_q.eff[i], clamp_notch(wv), rng)) begin
                s_d.eff[i] = s_q.eff[i];                            // [R10]
              end else begin
                s_d.eff[i] = clamp_notch(wv);                       // [R10]
              end
            end
          end
        end
        SNAV_OFS_FW_TEN: s_d.fw10 = wv;
        SNAV_OFS_FW_ONE: s_d.fw1  = wv;
        SNAV_OFS_GAIN1: begin
          s_d.g1 = (gv < SNAV_G1_MIN) ? SNAV_G1_MIN : gv;            // [R18]
        end
        SNAV_OFS_GAIN2: begin
          s_d.g2 = (gv < SNAV_G2_MIN) ? SNAV_G2_MIN : gv;            // [R19]
        end
        SNAV_OFS_VCS:  s_d.gain_change_speed  = (wv > SNAV_VCS_MAX) ? SNAV_VCS_MAX : wv; // [R20]
        SNAV_OFS_VMAX: s_d.vmax = wv;
        default: ;
      endcase
      // positive bound shared by both gains; checked on the value just taken
      if (s_q.wr_addr == SNAV_OFS_GAIN1 && gv > SNAV_G_MAX) s_d.g1 = SNAV_G_MAX; // [R18]
      if (s_q.wr_addr == SNAV_OFS_GAIN2 && gv > SNAV_G_MAX) s_d.g2 = SNAV_G_MAX; // [R19]
    end

    // resonance estimation during rapid traverse
    thr = SNAV_SENS_STEP * ((sns == 4'h0) ? 16'(SNAV_SNS_ZERO) : 16'(sns)); // [R15]
    if (rapid_traverse && osc_valid && osc_amplitude >= thr &&        // [R3]
        osc_freq >= SNAV_EST_MIN && osc_freq <= SNAV_EST_MAX) begin   // [R6]
      s_d.est  = osc_freq;
      s_d.pend = 1'b1;
      s_d.hold = 32'({30'h0, s_q.fw10[SNAV_FW10_HLD_LO +: 2]} + 32'h1) * HOLD_STEP_CYC; // [R13]
    end else if (s_q.hold != 32'h0) begin
      s_d.hold = s_q.hold - 32'h1;
    end

    // retune only with the axis at rest; pending estimate then consumed
    if (s_q.pend && axis_at_rest && !rapid_traverse && !s_q.wr_pend) begin // [R3]
      s_d.pend = 1'b0;
      for (int i = 0; i < 4; i++) begin                             // [R4]
        if (ade[i] && s_q.prog[i] != 16'h0000 && in_win(s_q.est, s_q.prog[i], rng) &&
            diff16(s_q.est, s_q.prog[i]) < best_d) begin             // [R5]
          best   = 3'(i);
          best_d = diff16(s_q.est, s_q.prog[i]);
          take   = 1'b1;
        end
      end
      if (!take && allf && ade[3] && s_q.prog[3] != 16'h0000) begin  // [R8]
        best = 3'h3;                                                // [R9]
        take = 1'b1;
      end
      if (take) s_d.eff[best[1:0]] = s_q.est;                       // [R7]
    end

    // monitor display
    unique case (s_q.fw10[SNAV_FW10_SEL_LO +: 3])                   // [R12]
      SNAV_SEL_EST: s_d.mon = (s_q.hold != 32'h0) ? s_q.est : 16'h0000; // [R13]
      SNAV_SEL_N1:  s_d.mon = s_q.eff[0];
      SNAV_SEL_N2:  s_d.mon = s_q.eff[1];
      SNAV_SEL_N3:  s_d.mon = SNAV_NOTCH3_HZ;
      SNAV_SEL_N4:  s_d.mon = s_q.eff[2];
      SNAV_SEL_N5:  s_d.mon = s_q.eff[3];
      default:      s_d.mon = 16'h0000;
    endcase

    // standstill jitter: drop pulses after a polarity reversal
    s_d.pulse_out = 1'b0;
    if (fb_pulse) begin
      s_d.last_dir = fb_dir;
      s_d.dir_out  = fb_dir;
      s_d.pulse_out = 1'b1;
      if (!motor_stopped) begin                                    // [R17]
        s_d.drop = 2'h0;
      end else if (jit != 2'h0 && fb_dir != s_q.last_dir) begin     // [R16]
        s_d.pulse_out = 1'b0;
        s_d.drop = jit - 2'h1;
      end else if (s_q.drop != 2'h0) begin                          // [R16]
        s_d.pulse_out = 1'b0;
        s_d.drop = s_q.drop - 2'h1;
      end
    end

    // variable speed-loop gain
    lim = (24'(s_q.vmax) * SNAV_LIM_NUM) / SNAV_LIM_DEN;            // [R19]
    if (s_q.gain_change_speed == 16'h0000 || s_q.g2 == 16'sh0000 || motor_speed <= s_q.gain_change_speed) begin // [R20]
      s_d.gain_eff = 17'(s_q.g1);
    end else if (24'(motor_speed) >= lim) begin
      s_d.gain_eff = 17'(s_q.g2);                                   // [R19]
    end else begin
      num  = 41'(s_q.g2 - s_q.g1) * $signed({25'h0, motor_speed - s_q.gain_change_speed});
      den  = $signed({17'h0, lim - 24'(s_q.gain_change_speed)});
      step = num / den;                                             // [R21]
      s_d.gain_eff = 17'(s_q.g1) + step[16:0];                      // [R21]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{prog: {4{SNAV_RST_NOTCH}}, eff: {4{SNAV_RST_NOTCH}}, fw10: SNAV_RST_FW,
               fw1: SNAV_RST_FW, g1: SNAV_RST_GAIN1, g2: SNAV_RST_ZERO,
               gain_change_speed: SNAV_RST_ZERO, vmax: SNAV_RST_ZERO, est: SNAV_RST_ZERO,
               pend: 1'b0, hold: 32'h0, wr_pend: 1'b0, wr_addr: 8'h00,
               rdata: 32'h0, last_dir: 1'b0, drop: 2'h0, pulse_out: 1'b0,
               dir_out: 1'b0, gain_eff: 17'(SNAV_RST_GAIN1), mon: SNAV_RST_ZERO};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ready held low from reset to the first enabled clock, zero wait states after; every access answers okay, unmapped ones read zero
  logic [2:0] bus_q; // ready, response, filter 3 on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)    bus_q <= 3'b001;
    else if (clk_en) bus_q <= 3'b101;
  end

  assign hreadyout               = bus_q[2];
  assign hresp                   = bus_q[1];
  assign hrdata                  = s_q.rdata;
  assign fb_pulse_out            = s_q.pulse_out;
  assign fb_dir_out              = s_q.dir_out;
  assign notch_eff_freq          = s_q.eff;
  assign notch3_enable           = bus_q[0];
  assign resonance_monitor_value = s_q.mon;
  assign speed_gain_effective    = s_q.gain_eff;
endmodule : snav_ctrl

// File: tb/snav_ctrl_assertions.sv
// port-level checker for snav_ctrl, bound into every instance
// assumes clk_en stays high while the shadows follow register writes
`timescale 1ns/100ps
module snav_ctrl_chk
  import snav_pkg::*;
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               clk_en,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               axis_at_rest,
  input wire logic               motor_stopped,
  input wire logic               fb_pulse,
  input wire logic               fb_dir,
  input wire logic               fb_pulse_out,
  input wire logic               fb_dir_out,
  input wire logic [3:0][15:0]   notch_eff_freq,
  input wire logic               notch3_enable,
  input wire logic [15:0]        resonance_monitor_value,
  input wire logic signed [16:0] speed_gain_effective
);
  logic        wv_q, wr2_q, dir_q;
  logic [7:0]  wa_q;
  logic [15:0] fw10_q, fw1_q;
  // function word shadows, landing with the design's write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wv_q, wr2_q, dir_q, wa_q, fw10_q, fw1_q} <= '0;
    end else if (clk_en) begin
      wv_q  <= hsel && hready && htrans[1] && hwrite;
      wa_q  <= haddr[7:0];
      wr2_q <= wv_q;
      if (wv_q && wa_q == SNAV_OFS_FW_TEN) fw10_q <= hwdata[15:0];
      if (wv_q && wa_q == SNAV_OFS_FW_ONE) fw1_q <= hwdata[15:0];
      if (fb_pulse) dir_q <= fb_dir;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_filter3_fixed: assert property (notch3_enable == 1'b1)
    else $error("filter 3 not fixed on");
  a_no_ghost_pulse: assert property (fb_pulse_out |-> $past(fb_pulse))
    else $error("feedback pulse out without input");
  a_moving_pass: assert property (clk_en && fb_pulse && !motor_stopped
    |=> fb_pulse_out && fb_dir_out == $past(fb_dir)) else $error("pulse lost while moving");
  a_reverse_drop: assert property (clk_en && fb_pulse && motor_stopped
    && fb_dir != dir_q && fw1_q[5:4] != 2'h0 |=> !fb_pulse_out) else $error("reversal passed");
  a_retune_at_rest: assert property ($changed(notch_eff_freq)
    |-> $past(axis_at_rest) || wr2_q) else $error("retune while moving");
  a_est_window: assert property ((fw10_q[14:12] == SNAV_SEL_EST)[*3] |->
    resonance_monitor_value == 16'h0 || (resonance_monitor_value >= SNAV_EST_MIN
    && resonance_monitor_value <= SNAV_EST_MAX)) else $error("estimate out of range");
  a_filter3_shown: assert property ((fw10_q[14:12] == SNAV_SEL_N3)[*3]
    |-> resonance_monitor_value == SNAV_NOTCH3_HZ) else $error("filter 3 display wrong");
  a_filter1_shown: assert property (((fw10_q[14:12] == SNAV_SEL_N1)
    && $stable(notch_eff_freq))[*3] |-> resonance_monitor_value == notch_eff_freq[0])
    else $error("filter 1 display wrong");
  a_gain_range: assert property (speed_gain_effective >= SNAV_G2_MIN
    && speed_gain_effective <= SNAV_G_MAX) else $error("gain out of range");
  a_eff_limit: assert property (notch_eff_freq[2] <= SNAV_NOTCH_MAX
    && notch_eff_freq[3] <= SNAV_NOTCH_MAX) else $error("notch 4 or 5 above limit");
endmodule : snav_ctrl_chk

bind snav_ctrl snav_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .axis_at_rest(axis_at_rest), .motor_stopped(motor_stopped),
  .fb_pulse(fb_pulse), .fb_dir(fb_dir), .fb_pulse_out(fb_pulse_out),
  .fb_dir_out(fb_dir_out), .notch_eff_freq(notch_eff_freq), .notch3_enable(notch3_enable),
  .resonance_monitor_value(resonance_monitor_value),
  .speed_gain_effective(speed_gain_effective));

// File: tb/snav_far_model.sv
// far side: motion state, resonance estimator source and speed feedback encoder
// assumes the bench calls its tasks right after a rising edge
`timescale 1ns/100ps
module snav_far_model (
  input  wire logic        hclk,
  output logic             rapid_traverse,
  output logic             axis_at_rest,
  output logic             motor_stopped,
  output logic             osc_valid,
  output logic [15:0]      osc_freq,
  output logic [15:0]      osc_amplitude,
  output logic             fb_pulse,
  output logic             fb_dir
);
  initial {rapid_traverse, axis_at_rest, motor_stopped, osc_valid, fb_pulse, fb_dir} = '0;
  initial {osc_freq, osc_amplitude} = '0;
  task automatic osc(input logic [15:0] f, input logic [15:0] a);
    @(posedge hclk);
    {rapid_traverse, axis_at_rest, osc_valid} <= 3'b101;
    {osc_freq, osc_amplitude} <= {f, a};
    @(posedge hclk);
    osc_valid <= 1'b0;
    {osc_freq, osc_amplitude} <= {~f, ~a}; // stale values are not held
    @(posedge hclk);
    rapid_traverse <= 1'b0;
  endtask : osc
  task automatic stand(input logic rest, input logic stop);
    @(posedge hclk);
    {axis_at_rest, motor_stopped} <= {rest, stop};
  endtask : stand
  task automatic pulses(input logic d, input int n);
    repeat (n) begin
      @(posedge hclk);
      {fb_pulse, fb_dir} <= {1'b1, d};
      @(posedge hclk);
      {fb_pulse, fb_dir} <= {1'b0, ~d};
    end
  endtask : pulses
endmodule : snav_far_model

// File: tb/test_servo_notch_adaptive_vibration_ctrl.sv
// self-checking bench: ahb-lite register tasks, far-side model, integer reference model
// assumes the checker binds itself; display hold step shortened to 20 cycles
`timescale 1ns/100ps
module test_servo_notch_adaptive_vibration_ctrl;
  import snav_pkg::*;
  logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, clk_en, fpo, fdo, n3;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic               rt, ar, ms, ov, fp, fd, d;
  logic [15:0]        of, oa, motor_speed, mon, lfsr;
  logic [3:0][15:0]   eff;
  logic signed [16:0] gain;
  int                 err_count, cmp_count, cyc, opass, xp;
  int                 mreg[16], effm[4];
  logic [7:0]         ta[6] = '{8'h08, 8'h0c, 8'h18, 8'h18, 8'h1c, 8'h20};
  logic [15:0]        tv[6] = '{16'h0bb8, 16'h0bb8, 16'h0000, 16'h7531, 16'hf830, 16'h2ee0};
  int                 sp[5] = '{500, 1650, 2300, 3000, 1650};
  snav_ctrl #(.HOLD_STEP_CYC(32'd20)) DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rapid_traverse(rt), .axis_at_rest(ar), .osc_valid(ov), .osc_freq(of),
    .osc_amplitude(oa), .motor_stopped(ms), .fb_pulse(fp), .fb_dir(fd),
    .motor_speed(motor_speed), .fb_pulse_out(fpo), .fb_dir_out(fdo), .notch_eff_freq(eff),
    .notch3_enable(n3), .resonance_monitor_value(mon), .speed_gain_effective(gain));
  snav_far_model u_far (.hclk(hclk), .rapid_traverse(rt), .axis_at_rest(ar),
    .motor_stopped(ms), .osc_valid(ov), .osc_freq(of), .osc_amplitude(oa), .fb_pulse(fp),
    .fb_dir(fd));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (fpo === 1'b1) opass <= opass + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // waits on hreadyout with no assumed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(32'(hresp), 32'h0);
  endtask : bus
  function automatic int clampv(logic [7:0] a, int v);
    case (a)
      8'h08, 8'h0c: return v > 2250 ? 2250 : v;
      8'h18: return v < 1 ? 1 : (v > 30000 ? 30000 : v);
      8'h1c: return v < -1000 ? -1000 : (v > 30000 ? 30000 : v);
      8'h20: return v > 9999 ? 9999 : v;
      default: return v;
    endcase
  endfunction : clampv
  task automatic wr(input logic [7:0] a, input logic [15:0] wd);
    logic [31:0] r;
    int i, w;
    i = a >> 2;
    bus(1'b1, a, {16'h0, wd}, r);
    mreg[i] = clampv(a, (a == 8'h18 || a == 8'h1c) ? int'($signed(wd)) : int'(wd));
    w = mreg[i] * (mreg[4][5:4] + 1) / 10;
    if (i < 4 && (effm[i] > mreg[i] + w || effm[i] < mreg[i] - w)) effm[i] = mreg[i];
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd
  function automatic void retune(int est, int amp);
    int b, bd, dd, w, s;
    b = -1;
    bd = 1 << 20;
    s = mreg[4][3:0] == 0 ? 10 : mreg[4][3:0];
    if (amp < 64 * s || est < 150 || est > 900) return;
    for (int i = 0; i < 4; i++) begin
      w = mreg[i] * (mreg[4][5:4] + 1) / 10;
      dd = est > mreg[i] ? est - mreg[i] : mreg[i] - est;
      if (mreg[4][8 + i] && mreg[i] != 0 && dd <= w && dd < bd) begin
        b = i;
        bd = dd;
      end
    end
    if (b < 0 && mreg[4][15] && mreg[4][11] && mreg[3] != 0) b = 3;
    if (b >= 0) effm[b] = est;
  endfunction : retune
  task automatic chkeff();
    @(posedge hclk);
    for (int i = 0; i < 4; i++) chk(32'(eff[i]), 32'(effm[i]));
    rd(8'h34, {16'(effm[1]), 16'(effm[0])});
  endtask : chkeff
  task automatic adapt(input int f, input int a);
    u_far.osc(16'(f), 16'(a));
    repeat (4) @(posedge hclk);
    chkeff();
    u_far.stand(1'b1, 1'b0);
    repeat (4) @(posedge hclk);
    retune(f, a);
    chkeff();
    u_far.stand(1'b0, 1'b0);
  endtask : adapt
  function automatic int gm(int s);
    int l;
    l = mreg[9] * 115 / 100;
    if (mreg[8] == 0 || mreg[7] == 0 || s <= mreg[8]) return mreg[6];
    if (s >= l) return mreg[7];
    return mreg[6] + (mreg[7] - mreg[6]) * (s - mreg[8]) / (l - mreg[8]);
  endfunction : gm
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, motor_speed, cyc, opass} = '0;
    {hsize, clk_en, hresetn, lfsr} = {3'h2, 1'b1, 1'b0, 16'h25a7};
    foreach (mreg[i]) mreg[i] = (i == 6 || i == 12) ? 100 : 0;
    effm = '{0, 0, 0, 0};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 16; i++) rd(8'(i * 4), 32'(mreg[i]));
    foreach (ta[i]) begin
      wr(ta[i], tv[i]);
      rd(ta[i], 32'(mreg[ta[i] >> 2][15:0]));
    end
    repeat (8) begin
      lfsr = lfsr_next(lfsr);
      wr(8'h08, lfsr);
      rd(8'h08, 32'(mreg[2]));
    end
    $display("test registers done");
    wr(8'h00, 16'd300);
    wr(8'h04, 16'd340);
    wr(8'h10, 16'h0311);
    adapt(330, 256);
    wr(8'h10, 16'h0111);
    adapt(330, 256);
    wr(8'h0c, 16'd800);
    wr(8'h10, 16'h8911);
    adapt(950, 256);
    adapt(200, 256);
    wr(8'h00, 16'd320);
    chkeff();
    wr(8'h00, 16'd500);
    chkeff();
    wr(8'h10, 16'h0110);
    adapt(450, 600);
    adapt(450, 700);
    $display("test adaptive done");
    wr(8'h10, 16'h0050);
    u_far.osc(16'd600, 16'h0400);
    repeat (30) @(posedge hclk);
    chk(32'(mon), 32'd600);
    repeat (20) @(posedge hclk);
    chk(32'(mon), 32'h0);
    for (int c = 1; c < 6; c++) begin
      wr(8'h10, 16'(c << 12));
      repeat (3) @(posedge hclk);
      chk(32'(mon), c == 3 ? 32'(SNAV_NOTCH3_HZ) : 32'(effm[c - 1 - (c > 3)]));
    end
    $display("test monitor done");
    u_far.stand(1'b1, 1'b1);
    d = 1'b0;
    u_far.pulses(d, 1);
    xp = 1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h14, 16'(c << 4));
      d = ~d;
      u_far.pulses(d, 4);
      xp += 4 - c;
    end
    u_far.stand(1'b0, 1'b0);
    u_far.pulses(~d, 4);
    repeat (3) @(posedge hclk);
    chk(32'(opass), 32'(xp + 4));
    $display("test jitter done");
    wr(8'h18, 16'd1000);
    wr(8'h1c, 16'd200);
    wr(8'h20, 16'd1000);
    wr(8'h24, 16'd2000);
    foreach (sp[i]) begin
      if (i == 4) wr(8'h20, 16'h0);
      motor_speed <= 16'(sp[i]);
      repeat (3) @(posedge hclk);
      chk(32'(gain), 32'(gm(sp[i])));
    end
    $display("test gain done");
    end_sim();
  end
endmodule : test_servo_notch_adaptive_vibration_ctrl
